/* bus_sync_unit.sv */
// Bus synchronization unit: break, start, stop and edge timing with register access.
//
// Contract
// R01: Bit-serial mode flags rising edges in bit 6.
// R02: Reading status clears every defined flag.
// R03: Completed soft reset sets status bit 5.
// R04: Break timer overflow sets bit 4, interrupts.
// R05: Bit timer equals compare sets bit 3.
// R06: Stop condition sets status bit 2.
// R07: Start condition sets status bit 1.
// R08: Break timer reaching compare sets bit 0.
// R09: Control zero bit 6 selects bit-serial mode.
// R10: Control zero bit 5 enables compare interrupt.
// R11: Control zero bit 4 enables stop interrupt.
// R12: Control zero bit 3 enables start interrupt.
// R13: Control zero bit 2 enables whole unit.
// R14: Edge clear bit clears counters, self-clears later.
// R15: Soft reset bit restores defaults, self-clears later.
// R16: Software waits for bus release before switching.
// R17: Control one high nibble sets stop edge.
// R18: Control one low nibble sets start edge.
// R19: Break falling edge counts as edge one.
// R20: Flags always set; interrupt only when enabled. The break error interrupts with no enable.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module bus_sync_unit
	import sync_unit_pkg::*;
#(
	parameter int TIMER_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [31:0] rdata_out,
	// Bus receive pin from the transceiver
	input wire logic bus_rx_in,
	// Interrupt request
	output logic irq_out
);
	import sync_unit_pkg::*;

	initial begin
		if (TIMER_W < 4 || TIMER_W > 32) $error("TIMER_W out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	bus_edge_if edge_bus ();
	logic rst_busy, rst_done, clr_busy;
	logic rst_start, clr_start;
	bus_pin_sync u_pin (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(bus_rx_in),
		.edge_out(edge_bus.source)
	);
	settle_timer #(.CYCLES(SETTLE_CYCLES)) u_reset_hold (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.start_in(rst_start),
		.busy_out(rst_busy),
		.done_out(rst_done)
	);
	settle_timer #(.CYCLES(SETTLE_CYCLES)) u_clear_hold (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.start_in(clr_start),
		.busy_out(clr_busy),
		.done_out()
	);

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl0_r, ctrl1_r, status_r, status_set;
	logic [TIMER_W-1:0] sync_cmp_r, bit_timer_r;
	logic [BREAK_TIMER_W-1:0] break_cmp_r, break_timer_r;
	logic [3:0] fall_cnt_r, rise_cnt_r, fall_cnt_nxt, stop_cnt_nxt;
	sync_state_type state_r;
	logic enable, mode_bs, stop_rising;
	logic wr_ctrl0, wr_ctrl1, rd_status;
	logic brk_valid, brk_overflow, start_hit, stop_hit, cmp_hit;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
		hit = (a == target);
	endfunction : hit

	assign wr_ctrl0 = write_in && hit(addr_in, CTRL0_ADDR);
	assign wr_ctrl1 = write_in && hit(addr_in, CTRL1_ADDR);
	assign rd_status = read_in && hit(addr_in, STATUS_ADDR);
	assign enable = ctrl0_r[C0_ENABLE];
	// R09: mode select
	assign mode_bs = ctrl0_r[C0_MODE];
	assign stop_rising = ctrl0_r[C0_STOP_RISING];
	// R15: soft reset launch
	assign rst_start = wr_ctrl0 && wdata_in[C0_SOFT_RESET] && !rst_busy;
	// R14: edge clear launch
	assign clr_start = wr_ctrl0 && wdata_in[C0_EDGE_CLEAR] && !clr_busy && !rst_busy;

	////////////////////////////////////////////////////////////////////////////////
	// Software writes are ignored while the soft reset holds the unit at its defaults.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl0_r <= CTRL0_RESET;
			ctrl1_r <= CTRL1_RESET;
			sync_cmp_r <= TIMER_W'(SYNC_CMP_RESET);
			break_cmp_r <= BREAK_CMP_RESET;
		end else if (rst_busy) begin
			// R15: defaults held
			ctrl0_r <= CTRL0_RESET;
			ctrl1_r <= CTRL1_RESET;
			sync_cmp_r <= TIMER_W'(SYNC_CMP_RESET);
			break_cmp_r <= BREAK_CMP_RESET;
		end else begin
			if (wr_ctrl0 && !wdata_in[C0_SOFT_RESET]) begin
				ctrl0_r <= {wdata_in[7:2], 2'b00};
			end
			if (wr_ctrl1) begin
				ctrl1_r <= wdata_in[7:0];
			end
			if (write_in && hit(addr_in, SYNC_CMP_ADDR)) begin
				sync_cmp_r <= wdata_in[TIMER_W-1:0];
			end
			if (write_in && hit(addr_in, BREAK_CMP_ADDR)) begin
				break_cmp_r <= wdata_in[BREAK_TIMER_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Break timer counts core cycles while the bus is low and saturates at its top.
	assign brk_valid = enable && !edge_bus.level
		&& (break_timer_r + BREAK_TIMER_W'(1) == break_cmp_r);
	// Fires once, on the step into the top count, so a long break flags a single error.
	assign brk_overflow = enable && !edge_bus.level
		&& (break_timer_r == {{(BREAK_TIMER_W-1){1'b1}}, 1'b0});
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			break_timer_r <= '0;
		end else if (rst_busy || !enable || edge_bus.level) begin
			// R13: unit disabled
			break_timer_r <= '0;
		end else if (!(&break_timer_r)) begin
			break_timer_r <= break_timer_r + BREAK_TIMER_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge counters saturate so a noisy bus cannot wrap them into a false match.
	assign fall_cnt_nxt = (&fall_cnt_r) ? fall_cnt_r : fall_cnt_r + 4'h1;
	assign stop_cnt_nxt = stop_rising
		? ((&rise_cnt_r) ? rise_cnt_r : rise_cnt_r + 4'h1) : fall_cnt_nxt;
	// R18: start edge match
	assign start_hit = enable && state_r == WAIT_START && edge_bus.fall
		&& fall_cnt_nxt == ctrl1_r[C1_START_LSB +: 4];
	// R17: stop edge match
	assign stop_hit = enable && state_r == TIMING
		&& (stop_rising ? edge_bus.rise : edge_bus.fall)
		&& stop_cnt_nxt == ctrl1_r[C1_STOP_LSB +: 4];
	assign cmp_hit = enable && state_r == TIMING && bit_timer_r == sync_cmp_r;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fall_cnt_r <= 4'h0;
			rise_cnt_r <= 4'h0;
		end else if (rst_busy || clr_busy || clr_start || !enable) begin
			// R14: counters cleared
			fall_cnt_r <= 4'h0;
			rise_cnt_r <= 4'h0;
		end else if (brk_valid) begin
			// R19: break edge is one
			fall_cnt_r <= 4'h1;
			rise_cnt_r <= 4'h0;
		end else begin
			if (edge_bus.fall) begin
				fall_cnt_r <= fall_cnt_nxt;
			end
			if (edge_bus.rise && !(&rise_cnt_r)) begin
				rise_cnt_r <= rise_cnt_r + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// The bit timer holds its stopped value until a valid break or soft reset zeroes it, or a start edge rearms it.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= WAIT_START;
			bit_timer_r <= '0;
		end else if (rst_busy || clr_busy || !enable || brk_valid) begin
			state_r <= WAIT_START;
			if (rst_busy || brk_valid) begin
				bit_timer_r <= '0;
			end
		end else begin
			unique case (state_r)
				WAIT_START: begin
					if (start_hit) begin
						state_r <= TIMING;
						bit_timer_r <= '0;
					end
				end
				TIMING: begin
					if (stop_hit) begin
						state_r <= HELD;
					end else if (!(&bit_timer_r)) begin
						bit_timer_r <= bit_timer_r + TIMER_W'(1);
					end
				end
				HELD: begin
					state_r <= HELD;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Events set flags regardless of the interrupt enables; a set beats a read clear.
	always_comb begin
		status_set = 8'h00;
		// R08: valid break
		status_set[ST_BREAK] = brk_valid;
		// R07: start condition
		status_set[ST_START] = start_hit;
		// R06: stop condition
		status_set[ST_STOP] = stop_hit;
		// R05: compare match
		status_set[ST_CMP] = cmp_hit;
		// R04: break overflow
		status_set[ST_BRK_ERR] = brk_overflow;
		// R03: reset complete
		status_set[ST_RST_DONE] = rst_done;
		// R01: rising edge, bit-serial only
		status_set[ST_RISE] = enable && mode_bs && edge_bus.rise;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			status_r <= STATUS_RESET;
		end else if (rst_busy) begin
			status_r <= STATUS_RESET;
		end else begin
			// R02: clear on read
			status_r <= (rd_status ? 8'h00 : status_r) | status_set;
		end
	end

	// R20: shared interrupt, gated except break error
	assign irq_out = status_r[ST_BRK_ERR]
		// R10: compare interrupt enable
		|| (status_r[ST_CMP] && ctrl0_r[C0_CMP_IE])
		// R11: stop interrupt enable
		|| (status_r[ST_STOP] && ctrl0_r[C0_STOP_IE])
		// R12: start interrupt enable
		|| (status_r[ST_START] && ctrl0_r[C0_START_IE]);

	////////////////////////////////////////////////////////////////////////////////
	// Read data stand for exactly one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (!read_in) begin
			rdata_out <= 32'h0000_0000;
		end else begin
			unique case (addr_in)
				STATUS_ADDR: rdata_out <= {24'h00_0000, 1'b0, status_r[6:0]};
				CTRL0_ADDR: rdata_out <= {24'h00_0000, ctrl0_r[7:2], clr_busy, rst_busy};
				CTRL1_ADDR: rdata_out <= {24'h00_0000, ctrl1_r};
				BIT_TIMER_ADDR: rdata_out <= 32'(bit_timer_r);
				BREAK_TIMER_ADDR: rdata_out <= 32'(break_timer_r);
				SYNC_CMP_ADDR: rdata_out <= 32'(sync_cmp_r);
				BREAK_CMP_ADDR: rdata_out <= 32'(break_cmp_r);
				default: rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	property p_rise_flag;
		edge_bus.rise && enable && mode_bs && !rst_busy |=> status_r[ST_RISE];
	endproperty
	a_rise_flag: assert property (p_rise_flag) else $error("rise flag missed"); // R01
	property p_lin_no_rise;
		!mode_bs && !status_r[ST_RISE] && !rd_status |=> !status_r[ST_RISE];
	endproperty
	a_lin_no_rise: assert property (p_lin_no_rise) else $error("rise flag in LIN mode"); // R09
	property p_read_clear;
		rd_status && !rst_busy |=> status_r == $past(status_set);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared"); // R02
	property p_reset_done;
		rst_done |=> status_r[ST_RST_DONE] && !rst_busy;
	endproperty
	a_reset_done: assert property (p_reset_done) else $error("reset done missing"); // R03
	property p_overflow;
		brk_overflow && !rst_busy |=> status_r[ST_BRK_ERR] && irq_out;
	endproperty
	a_overflow: assert property (p_overflow) else $error("break error missed"); // R04
	property p_compare;
		cmp_hit && !rst_busy |=> status_r[ST_CMP];
	endproperty
	a_compare: assert property (p_compare) else $error("compare flag missed"); // R05
	property p_stop;
		stop_hit && !rst_busy && !clr_busy && !brk_valid |=> status_r[ST_STOP] && state_r == HELD;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken"); // R17
	property p_start;
		start_hit && !rst_busy && !clr_busy && !brk_valid |=> status_r[ST_START]
			&& state_r == TIMING && bit_timer_r == '0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken"); // R18
	property p_break;
		brk_valid && !rst_busy && !clr_busy |=> status_r[ST_BREAK] && fall_cnt_r == 4'h1;
	endproperty
	a_break: assert property (p_break) else $error("break edge not one"); // R19
	property p_irq_gate;
		!status_r[ST_BRK_ERR]
			&& !ctrl0_r[C0_CMP_IE] && !ctrl0_r[C0_STOP_IE]
			&& !ctrl0_r[C0_START_IE] |-> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt"); // R20
	property p_disabled;
		!enable |=> break_timer_r == '0 && state_r == WAIT_START;
	endproperty
	a_disabled: assert property (p_disabled) else $error("unit active while disabled"); // R13
	property p_edge_clear;
		clr_start |=> fall_cnt_r == 4'h0 && rise_cnt_r == 4'h0 && clr_busy;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge clear failed"); // R14
	property p_soft_reset;
		rst_start |=> ##1 ctrl1_r == CTRL1_RESET && status_r == STATUS_RESET && rst_busy;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed"); // R15
	property p_soft_clear;
		rst_busy |=> fall_cnt_r == 4'h0 && rise_cnt_r == 4'h0 && state_r == WAIT_START
			&& bit_timer_r == '0;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft reset left state"); // R15
	property p_held_timer;
		state_r == HELD && !rst_busy && !brk_valid |=> $stable(bit_timer_r);
	endproperty
	a_held_timer: assert property (p_held_timer) else $error("stopped timer moved"); // R17
	property p_overflow_top;
		brk_overflow && !rst_busy |=> &break_timer_r;
	endproperty
	a_overflow_top: assert property (p_overflow_top) else $error("early break error"); // R04
endmodule : bus_sync_unit

/* sync_unit_pkg.sv */
// Shared constants, register map and types of the bus synchronization unit.
package sync_unit_pkg;
	// Register byte addresses.
	localparam logic [31:0] STATUS_ADDR = 32'hffff_0780;
	localparam logic [31:0] CTRL0_ADDR = 32'hffff_0784;
	localparam logic [31:0] CTRL1_ADDR = 32'hffff_078c;
	localparam logic [31:0] BIT_TIMER_ADDR = 32'hffff_0790;
	localparam logic [31:0] BREAK_TIMER_ADDR = 32'hffff_0794;
	localparam logic [31:0] SYNC_CMP_ADDR = 32'hffff_0798;
	localparam logic [31:0] BREAK_CMP_ADDR = 32'hffff_079c;
	// Status bit positions.
	localparam int ST_BREAK = 0;
	localparam int ST_START = 1;
	localparam int ST_STOP = 2;
	localparam int ST_CMP = 3;
	localparam int ST_BRK_ERR = 4;
	localparam int ST_RST_DONE = 5;
	localparam int ST_RISE = 6;
	// Control zero bit positions.
	localparam int C0_SOFT_RESET = 0;
	localparam int C0_EDGE_CLEAR = 1;
	localparam int C0_ENABLE = 2;
	localparam int C0_START_IE = 3;
	localparam int C0_STOP_IE = 4;
	localparam int C0_CMP_IE = 5;
	localparam int C0_MODE = 6;
	localparam int C0_STOP_RISING = 7;
	// Control one fields.
	localparam int C1_START_LSB = 0;
	localparam int C1_STOP_LSB = 4;
	// Reset values.
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic [7:0] CTRL1_RESET = 8'h32;
	localparam logic [15:0] SYNC_CMP_RESET = 16'h0000;
	localparam logic [11:0] BREAK_CMP_RESET = 12'h200;
	// Self-clearing control bits hold for this long.
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETTLE_TIME_NS = 15000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BREAK_TIMER_W = 12;
	typedef enum logic [1:0] {WAIT_START, TIMING, HELD} sync_state_type;
endpackage : sync_unit_pkg

/* bus_edge_if.sv */
// Carrier for the settled bus level and its edge pulses.
`timescale 1ns/100ps
interface bus_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport source (output level, output rise, output fall);
	modport sink (input level, input rise, input fall);
endinterface : bus_edge_if

/* bus_pin_sync.sv */
// Three-stage pin synchroniser producing settled level and edge pulses.
`timescale 1ns/100ps
module bus_pin_sync (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Bus pin and settled view
	input wire logic pin_in,
	bus_edge_if.source edge_out
);
	logic s1_r, s2_r, s3_r, level_r, rise_r, fall_r;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// A change is accepted only once the last two stages agree.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			level_r <= 1'b1;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			rise_r <= (s2_r == s3_r) && s3_r && !level_r;
			fall_r <= (s2_r == s3_r) && !s3_r && level_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end
	assign edge_out.level = level_r;
	assign edge_out.rise = rise_r;
	assign edge_out.fall = fall_r;
endmodule : bus_pin_sync

/* settle_timer.sv */
// One-shot hold timer for self-clearing control bits.
`timescale 1ns/100ps
module settle_timer #(
	parameter int CYCLES = 600
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Control
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_r;
	logic done_r;
	initial begin
		if (CYCLES < 1) $error("settle_timer needs at least one cycle");
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= (count_r == CW'(1));
			if (count_r != '0) begin
				count_r <= count_r - CW'(1);
			end else if (start_in) begin
				count_r <= CW'(CYCLES);
			end
		end
	end
	assign busy_out = (count_r != '0);
	assign done_out = done_r;
endmodule : settle_timer

/* lin_node_model.sv */
// Behavioural bus node that drives the unit's receive line.
`timescale 1ns/100ps
module lin_node_model (
	// Clock
	input wire logic clk_in,
	// Bus level seen by the unit
	output logic bus_out
);
	// The bus has a pull-up, so a released line reads high.
	initial bus_out = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic hold_level(input logic level, input int cycles);
		bus_out <= level;
		repeat (cycles) @(posedge clk_in);
	endtask : hold_level

	// A break, a two-bit delimiter, then a sync byte of alternate bits with start and stop.
	task automatic send_frame(input int brk_cycles, input int bit_cycles);
		logic [9:0] frame;
		frame = {1'b1, 8'h55, 1'b0};
		hold_level(1'b0, brk_cycles);
		hold_level(1'b1, 2 * bit_cycles);
		for (int i = 0; i < 10; i++) begin
			hold_level(frame[i], bit_cycles);
		end
	endtask : send_frame
endmodule : lin_node_model

/* tb_top.sv */
// Self-checking bench for the bus synchronization unit.
`timescale 1ns/100ps
module tb_top;
	import sync_unit_pkg::*;
	localparam int TIMEOUT_CYCLES = 30000;
	localparam int BIT_CYCLES = 40;
	logic clk_in;
	logic reset_in;
	logic [31:0] addr_in;
	logic [31:0] wdata_in;
	logic write_in;
	logic read_in;
	logic [31:0] rdata_out;
	logic bus_rx_in;
	logic irq_out;
	int n_mismatch = 0;
	int checks = 0;
	int cycle_count = 0;
	int ie_bits[3] = '{C0_START_IE, C0_STOP_IE, C0_CMP_IE};

	////////////////////////////////////////////////////////////////////////////////
	bus_sync_unit #(.TIMER_W(16)) DUT (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.write_in(write_in),
		.read_in(read_in),
		.rdata_out(rdata_out),
		.bus_rx_in(bus_rx_in),
		.irq_out(irq_out)
	);

	lin_node_model node (
		.clk_in(clk_in),
		.bus_out(bus_rx_in)
	);

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
		@(posedge clk_in);
		write_in <= 1'b1;
		addr_in <= addr;
		wdata_in <= data;
		@(posedge clk_in);
		write_in <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic read_check(input logic [31:0] addr, input logic [31:0] exp,
			input logic [31:0] mask = 32'hffff_ffff);
		@(posedge clk_in);
		read_in <= 1'b1;
		addr_in <= addr;
		@(posedge clk_in);
		read_in <= 1'b0;
		#1;
		check(rdata_out & mask, exp);
	endtask : read_check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk_in) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == TIMEOUT_CYCLES) begin
			n_mismatch++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		reset_in = 1'b1;
		addr_in = 32'h0000_0000;
		wdata_in = 32'h0000_0000;
		write_in = 1'b0;
		read_in = 1'b0;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		read_check(STATUS_ADDR, 32'h0000_0000);
		read_check(CTRL1_ADDR, 32'h0000_0032);
		read_check(CTRL0_ADDR, 32'h0000_0000);
		reg_write(STATUS_ADDR, 32'h0000_00ff);
		read_check(STATUS_ADDR, 32'h0000_0000);
		read_check(32'hffff_07a0, 32'h0000_0000);
		$display("test reset values done");
		// Flags come up with every interrupt enable off.
		reg_write(SYNC_CMP_ADDR, 32'h0000_0028);
		reg_write(CTRL0_ADDR, 32'h0000_0004);
		node.send_frame(600, BIT_CYCLES);
		repeat (8) @(posedge clk_in);
		check({31'h0, irq_out}, 32'h0000_0000);
		read_check(STATUS_ADDR, 32'h0000_000f);
		// The timer starts at zero on the start edge and the stop edge freezes it.
		read_check(BIT_TIMER_ADDR, 32'(2 * BIT_CYCLES - 1));
		read_check(STATUS_ADDR, 32'h0000_0000);
		$display("test frame flags done");
		foreach (ie_bits[k]) begin
			reg_write(CTRL0_ADDR, 32'h0000_0004 | (32'h0000_0001 << ie_bits[k]));
			node.send_frame(600, BIT_CYCLES);
			repeat (8) @(posedge clk_in);
			check({31'h0, irq_out}, 32'h0000_0001);
			read_check(STATUS_ADDR, 32'h0000_000f);
			check({31'h0, irq_out}, 32'h0000_0000);
		end
		$display("test interrupt enables done");
		reg_write(CTRL0_ADDR, 32'h0000_0004);
		node.hold_level(1'b0, 4300);
		node.hold_level(1'b1, 20);
		check({31'h0, irq_out}, 32'h0000_0001);
		read_check(STATUS_ADDR, 32'h0000_0011);
		check({31'h0, irq_out}, 32'h0000_0000);
		$display("test break overflow done");
		// line has been idle high since the break ended, so the mode may change.
		reg_write(CTRL0_ADDR, 32'h0000_0044);
		node.hold_level(1'b0, 20);
		node.hold_level(1'b1, 20);
		read_check(STATUS_ADDR, 32'h0000_0040, 32'h0000_0040);
		$display("test bit-serial edge done");
		// A falling edge right after clearing the counters must count as the first edge, not a start.
		// Disabling first clears the counters and stops the timer left running by the edge test.
		reg_write(CTRL0_ADDR, 32'h0000_0000);
		reg_write(CTRL0_ADDR, 32'h0000_0004);
		read_check(STATUS_ADDR, 32'h0000_0000);
		node.hold_level(1'b0, 600);
		node.hold_level(1'b1, BIT_CYCLES);
		reg_write(CTRL0_ADDR, 32'h0000_0006);
		read_check(CTRL0_ADDR, 32'h0000_0006);
		repeat (SETTLE_CYCLES + 4) @(posedge clk_in);
		read_check(CTRL0_ADDR, 32'h0000_0004);
		node.hold_level(1'b0, BIT_CYCLES);
		node.hold_level(1'b1, BIT_CYCLES);
		read_check(STATUS_ADDR, 32'h0000_0001);
		$display("test edge clear done");
		reg_write(CTRL1_ADDR, 32'h0000_0045);
		read_check(CTRL1_ADDR, 32'h0000_0045);
		reg_write(CTRL0_ADDR, 32'h0000_0005);
		read_check(CTRL0_ADDR, 32'h0000_0001);
		reg_write(CTRL1_ADDR, 32'h0000_0099);
		read_check(CTRL1_ADDR, 32'h0000_0032);
		repeat (SETTLE_CYCLES + 4) @(posedge clk_in);
		read_check(CTRL0_ADDR, 32'h0000_0000);
		read_check(STATUS_ADDR, 32'h0000_0020);
		read_check(CTRL1_ADDR, 32'h0000_0032);
		$display("test soft reset done");
		complete_run();
	end
endmodule : tb_top
